// File: common/phy_mgmt_pkg.sv
// Package: register map, field positions, reset values and timing counts.
package phy_mgmt_pkg;

  // ----------------------------------------------------------------
  // Register indices on the serial management interface
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_AN_EN_BIT   = 12;
  localparam int CTRL_RESTART_BIT = 9;
  localparam int CTRL_DUPLEX_BIT  = 8;
  localparam int CTRL_COLTEST_BIT = 7;
  localparam int STAT_T4_BIT      = 15;
  localparam int STAT_CAP_LSB     = 11;
  localparam int STAT_PRE_BIT     = 6;
  localparam int STAT_ANC_BIT     = 5;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic       AN_EN_RST   = 1'b1;
  localparam logic       DUPLEX_RST  = 1'b1;
  localparam logic [3:0] CAP_RST     = 4'hF;
  localparam logic       PRE_SUPP    = 1'b1;
  localparam logic       T4_CAPABLE  = 1'b0;

  // ----------------------------------------------------------------
  // Management frame layout
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [3:0] HDR_LAST   = 4'hB;
  localparam logic [3:0] DATA_LAST  = 4'hF;

  // ----------------------------------------------------------------
  // Collision test timing
  // ----------------------------------------------------------------
  localparam int CLK_PS         = 20000;
  localparam int BT_100_PS      = 10000;
  localparam int COL_ON_MAX_BT  = 512;
  localparam int COL_OFF_MAX_BT = 4;
  // Worst case is the short bit time at 100 Mb/s; longest times round down.
  localparam int COL_ON_MAX_CYC  = (COL_ON_MAX_BT * BT_100_PS) / CLK_PS;
  localparam int COL_OFF_MAX_CYC = (COL_OFF_MAX_BT * BT_100_PS) / CLK_PS;
  localparam int COL_LAT_CYC     = 1;

endpackage : phy_mgmt_pkg

// File: design/mdio_frame_engine.sv
// Serial management frame decoder and read data shifter.
`timescale 1ns/1ps
module mdio_frame_engine (
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // Management pins
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  // Device address and register side
  input  wire logic [4:0]  phy_addr,
  input  wire logic [15:0] rd_data,
  output logic [4:0]       reg_addr,
  output logic             wr_strobe,
  output logic [15:0]      wr_data
);

  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_TA, ST_DATA} fstate_t;

  fstate_t     state_q, state_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [11:0] hdr_q, hdr_d;
  logic [15:0] sh_q, sh_d;
  logic        prev_q, prev_d;
  logic        mdc_q;
  logic        rd_q, rd_d;
  logic        out_d, oe_d, wst_d;
  logic [4:0]  ra_d;
  logic        edge_r;
  logic [11:0] hdr_n;
  logic        hit;

  assign edge_r = mdc & ~mdc_q;
  assign hdr_n  = {hdr_q[10:0], mdio_in};
  // Only the two registers of this block are claimed.
  assign hit    = (hdr_n[9:5] == phy_addr) && (hdr_n[4:1] == 4'h0);

  // Frame sequencing; all bits are sampled on rising MDC edges.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    hdr_d   = hdr_q;
    sh_d    = sh_q;
    prev_d  = prev_q;
    rd_d    = rd_q;
    out_d   = mdio_out;
    oe_d    = mdio_oe;
    wst_d   = 1'b0;
    ra_d    = reg_addr;
    if (edge_r) begin
      case (state_q)
        ST_IDLE: begin
          // A bare 0 then 1 starts a frame: no preamble needed.
          prev_d = mdio_in;
          if (!prev_q && mdio_in) begin
            state_d = ST_HDR;
            cnt_d   = 4'h0;
          end
        end
        ST_HDR: begin
          hdr_d = hdr_n;
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == phy_mgmt_pkg::HDR_LAST) begin
            state_d = ST_TA;
            cnt_d   = 4'h0;
            ra_d    = hdr_n[4:0];
            rd_d    = (hdr_n[11:10] == phy_mgmt_pkg::OP_READ) && hit;
            if (!hit || (hdr_n[11:10] != phy_mgmt_pkg::OP_WRITE &&
                         hdr_n[11:10] != phy_mgmt_pkg::OP_READ)) begin
              hdr_d[11:10] = 2'h0;
            end
          end
        end
        ST_TA: begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'h0) begin
            oe_d  = rd_q;
            out_d = 1'b0;
          end else begin
            state_d = ST_DATA;
            cnt_d   = 4'h0;
            out_d   = rd_data[15];
            sh_d    = {rd_data[14:0], 1'b0};
          end
        end
        ST_DATA: begin
          cnt_d = cnt_q + 4'h1;
          if (rd_q) begin
            out_d = sh_q[15];
            sh_d  = {sh_q[14:0], 1'b0};
          end else begin
            sh_d  = {sh_q[14:0], mdio_in};
          end
          if (cnt_q == phy_mgmt_pkg::DATA_LAST) begin
            state_d = ST_IDLE;
            prev_d  = 1'b1;
            oe_d    = 1'b0;
            wst_d   = hdr_q[11:10] == phy_mgmt_pkg::OP_WRITE;
          end
        end
        default: begin
          state_d = ST_IDLE;
          oe_d    = 1'b0;
        end
      endcase
    end
  end

  // State registers, frozen while the enable is low.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 4'h0;
      hdr_q     <= 12'h000;
      sh_q      <= 16'h0000;
      prev_q    <= 1'b1;
      mdc_q     <= 1'b0;
      rd_q      <= 1'b0;
      mdio_out  <= 1'b0;
      mdio_oe   <= 1'b0;
      wr_strobe <= 1'b0;
      reg_addr  <= 5'h00;
      wr_data   <= 16'h0000;
    end else if (ce) begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      hdr_q     <= hdr_d;
      sh_q      <= sh_d;
      prev_q    <= prev_d;
      mdc_q     <= mdc;
      rd_q      <= rd_d;
      mdio_out  <= out_d;
      mdio_oe   <= oe_d;
      wr_strobe <= wst_d;
      reg_addr  <= ra_d;
      wr_data   <= sh_d;
    end
  end

endmodule : mdio_frame_engine

// File: design/phy_mgmt_control_status_bits.sv
// Basic control and status register bits with collision test logic.
`timescale 1ns/1ps
// Notes on behaviour
// - Control bit 12 enables auto-negotiation.
// - Writing restart bit 9 starts negotiation.
// - Restart writes ignored while negotiation disabled.
// - Writing 0 mid-cycle changes nothing.
// - Restart reads 1 until done, self-clears.
// - Bit 8 forces duplex; strap sets reset.
// - Collision test raises COL after transmit enable.
// - COL drops soon after transmit enable drops.
// - Four-pair capability bit always reads 0.
// - Capability bits default 1, straps clear them.
// - Preamble suppression reads 1, frames decoded.
// - Complete bit set only after negotiation finishes.
// - Complete bit reads 0 when negotiation disabled.
module phy_mgmt_control_status_bits (
  // Clock, reset and enable
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  // Management pins and device address
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  input  wire logic [4:0] phy_addr,
  // Strap pins
  input  wire logic       strap_full_duplex,
  input  wire logic [3:0] strap_cap,
  // Negotiation engine
  input  wire logic       an_done,
  input  wire logic       an_full_duplex,
  output logic            an_enable,
  output logic            an_restart,
  output logic            full_duplex,
  // Media access signals
  input  wire logic       tx_en,
  output logic            col
);

  logic        an_en_q, an_en_d;
  logic        restart_q, restart_d;
  logic        complete_q, complete_d;
  logic        duplex_q, duplex_d;
  logic        coltest_q, coltest_d;
  logic [3:0]  cap_q, cap_d;
  logic        strap_done_q, strap_done_d;
  logic        an_restart_d, full_duplex_d, col_d;
  logic [4:0]  reg_addr;
  logic        wr_strobe;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic        ctrl_wr;

  // ----------------------------------------------------------------
  // Management frame engine
  // ----------------------------------------------------------------
  mdio_frame_engine u_frame (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .mdc       (mdc),
    .mdio_in   (mdio_in),
    .mdio_out  (mdio_out),
    .mdio_oe   (mdio_oe),
    .phy_addr  (phy_addr),
    .rd_data   (rd_data),
    .reg_addr  (reg_addr),
    .wr_strobe (wr_strobe),
    .wr_data   (wr_data)
  );

  // Status writes fall through untouched; only control is writable.
  assign ctrl_wr = wr_strobe && (reg_addr == phy_mgmt_pkg::REG_CTRL);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------

  // Unimplemented and reserved bits read as zero.
  always_comb begin
    rd_data = 16'h0000;
    if (reg_addr == phy_mgmt_pkg::REG_CTRL) begin
      rd_data[phy_mgmt_pkg::CTRL_AN_EN_BIT]   = an_en_q;
      rd_data[phy_mgmt_pkg::CTRL_RESTART_BIT] = restart_q;
      rd_data[phy_mgmt_pkg::CTRL_DUPLEX_BIT]  = duplex_q;
      rd_data[phy_mgmt_pkg::CTRL_COLTEST_BIT] = coltest_q;
    end else begin
      rd_data[phy_mgmt_pkg::STAT_T4_BIT] = phy_mgmt_pkg::T4_CAPABLE;
      rd_data[phy_mgmt_pkg::STAT_CAP_LSB +: 4] = cap_q;
      rd_data[phy_mgmt_pkg::STAT_PRE_BIT] = phy_mgmt_pkg::PRE_SUPP;
      // Gated by the enable so a stale result never shows.
      rd_data[phy_mgmt_pkg::STAT_ANC_BIT] = complete_q & an_en_q;
    end
  end

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------

  // Next values: straps first, then negotiation events, then writes,
  // so that a restart written in the finishing cycle is not lost.
  always_comb begin
    an_en_d      = an_en_q;
    restart_d    = restart_q;
    complete_d   = complete_q;
    duplex_d     = duplex_q;
    coltest_d    = coltest_q;
    cap_d        = cap_q;
    strap_done_d = 1'b1;
    an_restart_d = 1'b0;
    if (!strap_done_q) begin
      duplex_d = strap_full_duplex;
      cap_d    = cap_q & strap_cap;
    end
    if (an_done && an_en_q) begin
      restart_d  = 1'b0;
      complete_d = 1'b1;
    end
    if (ctrl_wr) begin
      an_en_d   = wr_data[phy_mgmt_pkg::CTRL_AN_EN_BIT];
      duplex_d  = wr_data[phy_mgmt_pkg::CTRL_DUPLEX_BIT];
      coltest_d = wr_data[phy_mgmt_pkg::CTRL_COLTEST_BIT];
      // A written 0 on restart is simply never looked at.
      if (an_en_q && wr_data[phy_mgmt_pkg::CTRL_RESTART_BIT]) begin
        restart_d    = 1'b1;
        complete_d   = 1'b0;
        an_restart_d = 1'b1;
      end
    end
    // Disabling abandons any cycle, so restart cannot stick at 1,
    // and a restart written together with the disable sends no pulse.
    if (!an_en_d) begin
      restart_d    = 1'b0;
      an_restart_d = 1'b0;
      complete_d = 1'b0;
    end
  end

  // Duplex in use: negotiated result, or the forced bit when disabled.
  always_comb begin
    full_duplex_d = an_en_d ? an_full_duplex : duplex_d;
  end

  // Collision test: one register stage keeps COL well inside both
  // limits, COL_ON_MAX_CYC and COL_OFF_MAX_CYC, at either rate.
  always_comb begin
    col_d = coltest_d & tx_en;
  end

  // Registers; straps are caught on the first enabled edge after reset.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      an_en_q      <= phy_mgmt_pkg::AN_EN_RST;
      restart_q    <= 1'b0;
      complete_q   <= 1'b0;
      duplex_q     <= phy_mgmt_pkg::DUPLEX_RST;
      coltest_q    <= 1'b0;
      cap_q        <= phy_mgmt_pkg::CAP_RST;
      strap_done_q <= 1'b0;
      an_enable    <= phy_mgmt_pkg::AN_EN_RST;
      an_restart   <= 1'b0;
      full_duplex  <= phy_mgmt_pkg::DUPLEX_RST;
      col          <= 1'b0;
    end else if (ce) begin
      an_en_q      <= an_en_d;
      restart_q    <= restart_d;
      complete_q   <= complete_d;
      duplex_q     <= duplex_d;
      coltest_q    <= coltest_d;
      cap_q        <= cap_d;
      strap_done_q <= strap_done_d;
      an_enable    <= an_en_d;
      an_restart   <= an_restart_d;
      full_duplex  <= full_duplex_d;
      col          <= col_d;
    end
  end

endmodule : phy_mgmt_control_status_bits

// File: tb/phy_mgmt_control_status_bits_props.sv
// Checker for the control, status and collision ports of the block.
`timescale 1ns/1ps
module phy_mgmt_checker (
  // Clock, reset and enable
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       ce,
  // Management pins
  input wire logic       mdc,
  input wire logic       mdio_in,
  input wire logic       mdio_out,
  input wire logic       mdio_oe,
  input wire logic [4:0] phy_addr,
  // Straps, negotiation and media access
  input wire logic       strap_full_duplex,
  input wire logic [3:0] strap_cap,
  input wire logic       an_done,
  input wire logic       an_full_duplex,
  input wire logic       an_enable,
  input wire logic       an_restart,
  input wire logic       full_duplex,
  input wire logic       tx_en,
  input wire logic       col
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);
  // MDC rise is seen one clock late, so outputs move one clock after it.
  sequence mdc_rise_s;
    $past(mdc) && !$past(mdc, 2);
  endsequence
  // A read drives 17 MDC periods, far longer than eight clocks.
  sequence drive_hold_s;
    mdio_oe [*8];
  endsequence
  col_release_a: assert property (!tx_en |=> !col)
    else $error("col stays high after transmit enable fell");
  col_cause_a: assert property (col |-> $past(tx_en))
    else $error("col high without transmit enable");
  restart_pulse_a: assert property (an_restart |=> !an_restart)
    else $error("restart pulse longer than one cycle");
  restart_gate_a: assert property (
    an_restart |-> an_enable && $past(an_enable, 2))
    else $error("restart accepted while negotiation disabled");
  duplex_follow_a: assert property (
    (an_enable && $stable(an_full_duplex)) [*3]
      |-> full_duplex == an_full_duplex)
    else $error("duplex ignores negotiated result");
  oe_edge_a: assert property ($changed(mdio_oe) |-> mdc_rise_s)
    else $error("drive enable moved off an MDC rise");
  out_edge_a: assert property (
    mdio_oe && $changed(mdio_out) |-> mdc_rise_s)
    else $error("read data moved off an MDC rise");
  turn_zero_a: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround bit not zero");
  drive_hold_a: assert property ($rose(mdio_oe) |-> drive_hold_s)
    else $error("read drive ended early");
endmodule : phy_mgmt_checker

bind phy_mgmt_control_status_bits phy_mgmt_checker chk (
  .clk(clk), .reset(reset), .ce(ce), .mdc(mdc), .mdio_in(mdio_in),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(phy_addr),
  .strap_full_duplex(strap_full_duplex), .strap_cap(strap_cap),
  .an_done(an_done), .an_full_duplex(an_full_duplex),
  .an_enable(an_enable), .an_restart(an_restart),
  .full_duplex(full_duplex), .tx_en(tx_en), .col(col));

// File: tb/mgmt_station.sv
// Management station model that sends serial management frames.
`timescale 1ns/1ps
module mgmt_station (
  // Clock
  input  wire logic clk,
  // Management pins
  output logic      mdc,
  output logic      mdio,
  input  wire logic dev_out,
  input  wire logic dev_oe
);
  logic drv;
  logic drv_en;
  // The line has a pull-up, so a released MDIO reads high.
  assign mdio = dev_oe ? dev_out : (drv_en ? drv : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
    drv_en = 1'b0;
  end
  // Start, op, addresses, turnaround, data; MSB first, no preamble.
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [31:0] bits;
    bits = {2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'hFFFF;
    for (int i = 31; i >= 0; i--) begin
      mdc = 1'b0;
      drv_en = !(op == phy_mgmt_pkg::OP_READ && i < 18);
      drv = bits[i];
      repeat (4) @(negedge clk);
      if (i < 16) rd[i] = mdio;
      mdc = 1'b1;
      repeat (4) @(negedge clk);
    end
    mdc = 1'b0;
    drv_en = 1'b0;
    // One idle clock keeps back to back frames from driving twice at once.
    @(negedge clk);
  endtask : xfer
endmodule : mgmt_station

// File: tb/phy_mgmt_control_status_bits_bench.sv
// Testbench for the control and status bits over management frames.
`timescale 1ns/1ps
module phy_mgmt_control_status_bits_bench;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       mdc, mdio, mdio_out, mdio_oe;
  logic       an_done = 1'b0;
  logic       an_fd = 1'b0;
  logic       ce = 1'b1;
  logic       an_enable, an_restart, full_duplex, col;
  logic       tx_en = 1'b0;
  logic [15:0] d;
  int         error_cnt = 0;
  int         tests_run = 0;
  int         restarts = 0;

  always #10 clk = ~clk;

  // Straps clear the 100 half and 10 half abilities and select half duplex.
  phy_mgmt_control_status_bits uut (
    .clk(clk), .reset(reset), .ce(ce), .mdc(mdc), .mdio_in(mdio),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(5'h05),
    .strap_full_duplex(1'b0), .strap_cap(4'hA), .an_done(an_done),
    .an_full_duplex(an_fd), .an_enable(an_enable),
    .an_restart(an_restart), .full_duplex(full_duplex),
    .tx_en(tx_en), .col(col));

  mgmt_station sta (.clk(clk), .mdc(mdc), .mdio(mdio),
                    .dev_out(mdio_out), .dev_oe(mdio_oe));

  // Count restart pulses; each lasts one cycle.
  always @(posedge clk) if (an_restart === 1'b1) restarts++;

  task automatic check(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    sta.xfer(phy_mgmt_pkg::OP_WRITE, 5'h05, ra, wd, d);
  endtask : wr

  task automatic rc(input logic [4:0] pa, ra, input logic [15:0] exp);
    sta.xfer(phy_mgmt_pkg::OP_READ, pa, ra, 16'h0000, d);
    check("read data", d, exp);
  endtask : rc

  task automatic pulse_done;
    an_done = 1'b1;
    @(negedge clk);
    an_done = 1'b0;
  endtask : pulse_done

  task automatic col_after(input logic txv, input logic exp);
    tx_en = txv;
    repeat (2) @(negedge clk);
    check("col", {15'h0000, col}, {15'h0000, exp});
  endtask : col_after

  task automatic print_verdict;
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Budget is about twice the frame traffic below.
  initial begin
    #200us;
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    check("duplex", {15'h0000, full_duplex}, 16'h0000);
    check("an enable", {15'h0000, an_enable}, 16'h0001);
    // The strap chose half duplex, so a 1 here can only be negotiated.
    an_fd = 1'b1;
    repeat (2) @(negedge clk);
    check("duplex", {15'h0000, full_duplex}, 16'h0001);
    an_fd = 1'b0;
    rc(5'h05, 5'h01, 16'h5040);
    rc(5'h05, 5'h00, 16'h1000);
    rc(5'h06, 5'h00, 16'hFFFF);
    rc(5'h05, 5'h02, 16'hFFFF);
    wr(5'h01, 16'hFFFF);
    rc(5'h05, 5'h01, 16'h5040);
    wr(5'h00, 16'h1200);
    check("restarts", 16'(restarts), 16'h0001);
    wr(5'h00, 16'h1000);
    // A done pulse while the enable is low must leave restart pending.
    ce = 1'b0;
    pulse_done();
    ce = 1'b1;
    rc(5'h05, 5'h00, 16'h1200);
    pulse_done();
    rc(5'h05, 5'h00, 16'h1000);
    rc(5'h05, 5'h01, 16'h5060);
    wr(5'h00, 16'h0100);
    check("duplex", {15'h0000, full_duplex}, 16'h0001);
    check("an enable", {15'h0000, an_enable}, 16'h0000);
    rc(5'h05, 5'h01, 16'h5040);
    wr(5'h00, 16'h0300);
    pulse_done();
    rc(5'h05, 5'h00, 16'h0100);
    rc(5'h05, 5'h01, 16'h5040);
    check("restarts", 16'(restarts), 16'h0001);
    wr(5'h00, 16'h0080);
    check("duplex", {15'h0000, full_duplex}, 16'h0000);
    col_after(1'b1, 1'b1);
    col_after(1'b0, 1'b0);
    wr(5'h00, 16'h0000);
    col_after(1'b1, 1'b0);
    tx_en = 1'b0;
    print_verdict();
  end
endmodule : phy_mgmt_control_status_bits_bench
